/* verilog/fspc_pkg.sv */
// Package with register map, field positions, reset values and types of the flash control block.
package fspc_pkg;
   // =========================================================================
   // Register map.
   localparam int BUS_AW = 5;
   localparam logic [4:0] OFS_MSS = 5'h00;
   localparam logic [4:0] OFS_PMC = 5'h04;
   localparam logic [4:0] OFS_FWADDR = 5'h08;
   localparam logic [4:0] OFS_CMD = 5'h0c;
   localparam logic [4:0] OFS_STAT = 5'h10;
   localparam logic [4:0] OFS_BAUD = 5'h14;

   // =========================================================================
   // Reset values and fields.
   localparam logic [7:0] MSS_RESET = 8'hcf;
   localparam logic [7:0] PMC_RESET = 8'h04;
   localparam int PMC_MODE_LOW = 0;
   localparam int PMC_ADDR_SRC = 1;
   localparam int PMC_WED = 2;
   localparam int PMC_ONBOARD = 7;
   localparam int CMD_PROG = 0;
   localparam int CMD_ERASE = 1;
   localparam int CMD_DATA_LSB = 8;
   localparam int STAT_BLOCKED = 0;
   localparam int STAT_BAUD_OK = 1;
   localparam int STAT_ONBOARD = 2;

   // =========================================================================
   // Widths and timing.
   localparam int FL_AW = 16;
   localparam int FL_DW = 8;
   localparam int BAUD_W = 16;
   // The reset command byte is all zero, so the line stays low for start bit plus eight bits.
   localparam logic [3:0] RST_LOW_BITS_LAST = 4'h8;

   // =========================================================================
   // Types.
   typedef struct packed {
      logic [FL_AW-1:0] addr;
      logic [FL_DW-1:0] data;
      logic write;
      logic erase;
   } fspc_flash_cmd_t;

   typedef enum {BD_IDLE, BD_WAIT_LOW, BD_MEASURE, BD_LOCKED} fspc_baud_state_t;
endpackage : fspc_pkg

/* verilog/fspc_baud_detect.sv */
// Receive baud clock recovery from the programmer's reset command.
`timescale 1ns/10ps
module fspc_baud_detect
   import fspc_pkg::*;
#(
   parameter int W = BAUD_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic enable,
   input wire logic rxLevel,
   output logic [W-1:0] period,
   output logic locked,
   output logic baudTick
);
   fspc_baud_state_t state_q;
   logic enable_q;
   logic [3:0] pre_q;
   logic [W-1:0] period_q;
   logic [W-1:0] tick_q;
   logic baudTick_q;

   // =========================================================================
   // Measurement: the low time divided by nine is one bit time.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q <= BD_IDLE;
         enable_q <= 1'b0;
         pre_q <= 4'h0;
         period_q <= '0;
      end else begin
         enable_q <= enable;
         unique case (state_q)
            BD_IDLE: begin
               if (enable && !enable_q) begin
                  state_q <= BD_WAIT_LOW;
               end
            end
            BD_WAIT_LOW: begin
               // The edge that first sees the line low already counts one low cycle.
               pre_q <= 4'h1;
               period_q <= '0;
               if (!rxLevel) begin
                  state_q <= BD_MEASURE;
               end
            end
            BD_MEASURE: begin
               if (rxLevel) begin
                  state_q <= (period_q != '0) ? BD_LOCKED : BD_WAIT_LOW;
               end else if (pre_q == RST_LOW_BITS_LAST) begin
                  pre_q <= 4'h0;
                  period_q <= period_q + W'(1);
               end else begin
                  pre_q <= pre_q + 4'h1;
               end
            end
            BD_LOCKED: begin
            end
         endcase
         if (!enable) begin
            state_q <= BD_IDLE;
         end
      end
   end

   // =========================================================================
   // Bit-rate enable pulse, one clock wide, once per measured period.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         tick_q <= '0;
         baudTick_q <= 1'b0;
      end else if (state_q != BD_LOCKED) begin
         tick_q <= '0;
         baudTick_q <= 1'b0;
      end else if (tick_q == period_q - W'(1)) begin
         tick_q <= '0;
         baudTick_q <= 1'b1;
      end else begin
         tick_q <= tick_q + W'(1);
         baudTick_q <= 1'b0;
      end
   end

   assign period = period_q;
   assign locked = (state_q == BD_LOCKED);
   assign baudTick = baudTick_q;

   // =========================================================================
   // Checks.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   logic [W-1:0] gap_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         gap_q <= '0;
      end else if (!locked) begin
         // The first pulse comes a full period after the lock edge, so start one below zero.
         gap_q <= '1;
      end else if (baudTick_q) begin
         gap_q <= '0;
      end else begin
         gap_q <= gap_q + W'(1);
      end
   end

   a_lock_nonzero: assert property ($rose(locked) |-> period_q != '0)
      else $error("Locked with zero bit period.");
   a_tick_spacing: assert property (locked && $past(locked) && baudTick_q && gap_q != '0
         |-> gap_q == period_q - W'(1))
      else $error("Baud pulse spacing differs from measured period.");
   a_ninth_step: assert property (state_q == BD_MEASURE && !rxLevel
         && pre_q == RST_LOW_BITS_LAST |=> period_q == $past(period_q) + W'(1))
      else $error("Bit period not advanced after nine cycles.");
   c_locked: cover property ($rose(locked));
endmodule : fspc_baud_detect

/* verilog/fspc_ctrl.sv */
// Flash self-programming control: registers, address source, write guard, baud recovery.
`timescale 1ns/10ps
module fspc_ctrl
   import fspc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [BUS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic programmingModePin,
   input wire logic serialRxPin,
   input wire logic uartSelected,
   input wire logic [FL_AW-1:0] cpuFlashAddr,
   output fspc_flash_cmd_t flashCmd,
   output logic [7:0] memorySizeSelect,
   output logic selfProgModeLow,
   output logic baudTick
);
   logic ack_q;
   logic [31:0] rdata_q;
   logic [7:0] mss_q;
   logic [7:0] pmc_q;
   logic [FL_AW-1:0] fwAddr_q;
   logic blocked_q;
   fspc_flash_cmd_t cmd_q;
   logic [2:0] modeSync_q;
   logic [2:0] rxSync_q;
   logic onBoard_q;
   logic rxLevel_q;
   logic [BAUD_W-1:0] period;
   logic locked;
   logic wrEn;
   logic cmdReq;
   logic wed;
   logic addrFromFw;
   logic [FL_AW-1:0] addrSel;
   logic [31:0] rdMux;

   // =========================================================================
   // Avalon slave: one wait state, read data registered while waiting.
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wrEn = avs_write && ack_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (avs_address)
         OFS_MSS: rdMux[7:0] = mss_q;
         OFS_PMC: begin
            rdMux[7:0] = pmc_q;
            rdMux[PMC_ONBOARD] = onBoard_q;
         end
         OFS_FWADDR: rdMux[FL_AW-1:0] = fwAddr_q;
         OFS_STAT: begin
            rdMux[STAT_BLOCKED] = blocked_q;
            rdMux[STAT_BAUD_OK] = locked;
            rdMux[STAT_ONBOARD] = onBoard_q;
         end
         OFS_BAUD: rdMux[BAUD_W-1:0] = period;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= rdMux;
      end
   end
   assign avs_readdata = rdata_q;

   // =========================================================================
   // Memory size selection; the reset value forces start-up code to program it.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mss_q <= MSS_RESET;
      end else if (wrEn && avs_address == OFS_MSS) begin
         mss_q <= avs_writedata[7:0];
      end
   end
   assign memorySizeSelect = mss_q;

   // =========================================================================
   // Mode control and firmware address. Bit 7 is live status and is not stored.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pmc_q <= PMC_RESET;
      end else if (wrEn && avs_address == OFS_PMC) begin
         pmc_q <= {1'b0, 4'h0, avs_writedata[PMC_WED:0]};
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         fwAddr_q <= '0;
      end else if (wrEn && avs_address == OFS_FWADDR) begin
         fwAddr_q <= avs_writedata[FL_AW-1:0];
      end
   end

   // =========================================================================
   // Pin synchronisers: a change counts once the second and third stages agree.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         modeSync_q <= 3'h0;
         rxSync_q <= 3'h7;
         onBoard_q <= 1'b0;
         rxLevel_q <= 1'b1;
      end else begin
         modeSync_q <= {modeSync_q[1:0], programmingModePin};
         rxSync_q <= {rxSync_q[1:0], serialRxPin};
         if (modeSync_q[1] == modeSync_q[2]) begin
            onBoard_q <= modeSync_q[2];
         end
         if (rxSync_q[1] == rxSync_q[2]) begin
            rxLevel_q <= rxSync_q[2];
         end
      end
   end

   // =========================================================================
   // Address source. In on-board mode the mode-low and address-source bits are ignored; the write/erase disable bit still acts.
   assign addrFromFw = !onBoard_q && pmc_q[PMC_ADDR_SRC];
   assign addrSel = addrFromFw ? fwAddr_q : cpuFlashAddr;
   assign selfProgModeLow = !onBoard_q && pmc_q[PMC_MODE_LOW];

   // =========================================================================
   // Command issue and write guard. A blocked attempt leaves a sticky flag;
   // a new block in the clearing cycle wins over the clear.
   assign wed = pmc_q[PMC_WED];
   assign cmdReq = wrEn && avs_address == OFS_CMD
      && (avs_writedata[CMD_PROG] || avs_writedata[CMD_ERASE]);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cmd_q <= '0;
      end else begin
         cmd_q.addr <= addrSel;
         cmd_q.write <= cmdReq && !wed && avs_writedata[CMD_PROG];
         cmd_q.erase <= cmdReq && !wed && avs_writedata[CMD_ERASE];
         if (cmdReq && !wed) begin
            cmd_q.data <= avs_writedata[CMD_DATA_LSB +: FL_DW];
         end
      end
   end
   assign flashCmd = cmd_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         blocked_q <= 1'b0;
      end else if (cmdReq && wed) begin
         blocked_q <= 1'b1;
      end else if (wrEn && avs_address == OFS_STAT && avs_writedata[STAT_BLOCKED]) begin
         blocked_q <= 1'b0;
      end
   end

   // =========================================================================
   // Baud recovery runs only for serial on-board programming.
   fspc_baud_detect #(
      .W(BAUD_W)
   ) u_baud (
      .clock(clock),
      .nrst(nrst),
      .enable(onBoard_q && uartSelected),
      .rxLevel(rxLevel_q),
      .period(period),
      .locked(locked),
      .baudTick(baudTick)
   );

   // =========================================================================
   // Checks.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   logic rstSeen_q;
   always_ff @(posedge clock) begin
      rstSeen_q <= !nrst;
   end

   a_mss_reset_value: assert property (rstSeen_q |-> mss_q == MSS_RESET)
      else $error("Memory size selection not at prohibited reset value.");
   a_guard_no_pulse: assert property (cmdReq && wed |=> !cmd_q.write && !cmd_q.erase)
      else $error("Flash command issued while write/erase disabled.");
   a_guard_flag_set: assert property (cmdReq && wed |=> blocked_q)
      else $error("Blocked command not flagged.");
   a_cmd_pass_through: assert property (cmdReq && !wed && avs_writedata[CMD_PROG]
         |=> cmd_q.write ##1 !cmd_q.write)
      else $error("Allowed write command not issued as single pulse.");
   a_cpu_addr_src: assert property (!onBoard_q && !pmc_q[PMC_ADDR_SRC]
         |=> cmd_q.addr == $past(cpuFlashAddr))
      else $error("CPU address not used as flash address.");
   a_fw_addr_src: assert property (!onBoard_q && pmc_q[PMC_ADDR_SRC]
         |=> cmd_q.addr == $past(fwAddr_q))
      else $error("Firmware address not used as flash address.");
   a_onboard_ignore: assert property (onBoard_q |-> !selfProgModeLow
         ##1 cmd_q.addr == $past(cpuFlashAddr))
      else $error("Mode bits acted in on-board mode.");
   a_bus_answer: assert property (avs_read || avs_write |-> ##[0:1] !avs_waitrequest)
      else $error("Bus request not answered within one wait state.");
   c_blocked: cover property (cmdReq && wed);
   c_erase: cover property (cmd_q.erase);
   c_fw_source: cover property (addrFromFw ##1 cmd_q.write);
endmodule : fspc_ctrl

/* verification/fspc_programmer_model.sv */
// Model of the external programmer that enters on-board mode and sends the reset command.
`timescale 1ns/10ps
module fspc_programmer_model #(
   parameter int BIT_CLOCKS = 20
) (
   input wire logic clock,
   input wire logic start,
   output logic modePin,
   output logic rxLine
);
   // =========================================================================
   // Frame generation.
   // The receive line idles high like a pulled-up line, so the device sees no false start bit.
   initial begin
      modePin = 1'b0;
      rxLine = 1'b1;
      @(posedge start);
      @(posedge clock);
      modePin <= 1'b1;
      repeat (10) @(posedge clock);
      // All-zero reset command: start bit and eight data bits low, then the stop bit high.
      rxLine <= 1'b0;
      repeat (9 * BIT_CLOCKS) @(posedge clock);
      rxLine <= 1'b1;
   end
endmodule : fspc_programmer_model

/* verification/test_flash_self_programming_control.sv */
// Self-checking testbench of the flash self-programming control block.
`timescale 1ns/10ps
module test_flash_self_programming_control
   import fspc_pkg::*;
;
   localparam int BIT_CLOCKS = 20;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [BUS_AW-1:0] avsAddress = '0;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = '0;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   logic modePin;
   logic rxLine;
   logic uartSelected = 1'b0;
   logic [FL_AW-1:0] cpuFlashAddr = '0;
   fspc_flash_cmd_t flashCmd;
   logic [7:0] memorySizeSelect;
   logic selfProgModeLow;
   logic baudTick;
   logic progStart = 1'b0;
   int error_cnt = 0;
   int check_count = 0;
   int cycleCount = 0;
   int seed = 32'h429a;
   int gap;
   logic [31:0] readQ[$];
   fspc_flash_cmd_t cmdQ[$];
   fspc_flash_cmd_t expCmd;
   logic [7:0] dataByte;
   logic [15:0] fwAddr;

   always #5 clock = ~clock;

   fspc_ctrl fspc_ctrl_i (.clock(clock), .nrst(nrst), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .programmingModePin(modePin), .serialRxPin(rxLine), .uartSelected(uartSelected),
      .cpuFlashAddr(cpuFlashAddr), .flashCmd(flashCmd), .memorySizeSelect(memorySizeSelect),
      .selfProgModeLow(selfProgModeLow), .baudTick(baudTick));

   fspc_programmer_model #(.BIT_CLOCKS(BIT_CLOCKS)) fspc_programmer_model_i (.clock(clock),
      .start(progStart), .modePin(modePin), .rxLine(rxLine));

   // =========================================================================
   // Compare and report.
   task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : checkWord

   task automatic checkCmd(input fspc_flash_cmd_t exp, input fspc_flash_cmd_t got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch flash command expected %h seen %h", exp, got);
      end
   endtask : checkCmd

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   // =========================================================================
   // Bus master.
   // Waitrequest is read right after the rising edge, before any design register has moved,
   // so it is the value sampled at that edge; the request is released only after it.
   task automatic busCycle(input logic [BUS_AW-1:0] addr, input logic rd, input logic [31:0] data);
      logic w;
      int n;
      n = 0;
      @(posedge clock);
      avsAddress <= addr;
      avsRead <= rd;
      avsWrite <= !rd;
      avsWritedata <= data;
      do begin
         @(posedge clock);
         w = avsWaitrequest;
         n++;
      end while (w !== 1'b0 && n < 50);
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (w !== 1'b0) begin
         checkWord("waitrequest", 32'h0, {31'h0, w});
         tally_and_finish();
      end
   endtask : busCycle

   task automatic busRead(input logic [BUS_AW-1:0] addr, input logic [31:0] exp);
      readQ.push_back(exp);
      busCycle(addr, 1'b1, 32'h0);
   endtask : busRead

   task automatic sendCmd(input logic [31:0] word, input logic [15:0] addr, input logic er);
      expCmd = '{addr: addr, data: word[15:8], write: !er, erase: er};
      cmdQ.push_back(expCmd);
      busCycle(OFS_CMD, 1'b0, word);
   endtask : sendCmd

   // =========================================================================
   // Output watcher and timeout.
   always @(posedge clock) begin
      if (avsRead && avsWaitrequest === 1'b0 && readQ.size() != 0) begin
         checkWord("read data", readQ.pop_front(), avsReaddata);
      end
      if (flashCmd.write === 1'b1 || flashCmd.erase === 1'b1) begin
         checkCmd((cmdQ.size() != 0) ? cmdQ.pop_front() : '0, flashCmd);
      end
   end

   always @(posedge clock) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 20000) begin
         checkWord("timeout", 32'h0, 32'h1);
         tally_and_finish();
      end
   end

   // =========================================================================
   // Main sequence.
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      checkWord("size port", 32'hcf, {24'h0, memorySizeSelect});
      busRead(OFS_MSS, {24'h0, MSS_RESET});
      busRead(OFS_PMC, 32'h4);
      busRead(5'h18, 32'h0);
      busCycle(OFS_MSS, 1'b0, 32'hc8);
      busRead(OFS_MSS, 32'hc8);
      checkWord("size port", 32'hc8, {24'h0, memorySizeSelect});
      $display("test reset and size done");
      // Disable still set from reset: the command must not reach the array.
      busCycle(OFS_CMD, 1'b0, 32'h0000_aa01);
      busRead(OFS_STAT, 32'h1);
      busCycle(OFS_STAT, 1'b0, 32'h1);
      busRead(OFS_STAT, 32'h0);
      $display("test blocked command done");
      @(posedge clock);
      cpuFlashAddr <= 16'($random(seed));
      dataByte = 8'($random(seed));
      fwAddr = 16'($random(seed));
      busCycle(OFS_PMC, 1'b0, 32'h0);
      sendCmd({16'h0, dataByte, 8'h01}, cpuFlashAddr, 1'b0);
      busCycle(OFS_FWADDR, 1'b0, {16'h0, fwAddr});
      busCycle(OFS_PMC, 1'b0, 32'h3);
      @(negedge clock);
      checkWord("mode low", 32'h1, {31'h0, selfProgModeLow});
      sendCmd({16'h0, dataByte, 8'h02}, fwAddr, 1'b1);
      $display("test address source done");
      // Mode bits stay set while the programmer takes over; on-board mode must override them.
      uartSelected <= 1'b1;
      progStart <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         gap = 0;
         do begin
            @(negedge clock);
            gap++;
         end while (baudTick !== 1'b1 && gap < 2000);
      end
      checkWord("tick spacing", BIT_CLOCKS, gap);
      checkWord("mode low onboard", 32'h0, {31'h0, selfProgModeLow});
      busRead(OFS_STAT, 32'h6);
      busRead(OFS_BAUD, BIT_CLOCKS);
      sendCmd({16'h0, dataByte, 8'h01}, cpuFlashAddr, 1'b0);
      busCycle(OFS_PMC, 1'b0, 32'h4);
      repeat (3) @(posedge clock);
      checkWord("pending notes", 32'h0, cmdQ.size() + readQ.size());
      $display("test on-board baud done");
      tally_and_finish();
   end
endmodule : test_flash_self_programming_control
